// ### umc_mux_ctrl.sv
// four-channel type-c port selector control core
// Behaviour
// - common port connects to one of 4 channels chosen by software
// - default operation never has two channels active at once
// - default mode routes every signal group to the selected channel
// - split mode gives each signal group its own channel assignment
// - only in split mode may vbus reach several channels
// - keep-alive charge feeds only unselected channels
// - split mode forces keep-alive charge off
// - overtemperature switches keep-alive charge outputs off
// - flip swaps side a and b of cc, sbu and data lines
// - detected cc orientation steers the side swap of cc, sbu and data lines alike
// - port command switches hs, ss and vbus together
// - data command switches hs and ss, vbus untouched
// - hs command switches only the hs pairs
// - one usb channel at index 0; channel commands must use it
// - save copies settings to the store, loaded as startup defaults
// - boost takes effect only after save and reset
// - reset button restores factory defaults
// - factory serial identifier readable by the host
// - all paths bidirectional, either side host or device
// - flip setting 0 normal, 1 flipped
// - keep-alive charge enable is bit 2 of the mode word
`timescale 1ns/1ps
module umc_mux_ctrl #(
  parameter logic [31:0] SERIAL_ID = 32'h0000_0001 // arbitrary value
) (
  // clock and resets
  input  wire logic                                            clk,
  input  wire logic                                            nrst,
  input  wire logic                                            por_nrst,
  // command port
  input  wire logic                                            cmd_valid,
  input  wire logic [3:0]                                      cmd_op,
  input  wire logic [7:0]                                      cmd_idx,
  input  wire logic [2:0]                                      cmd_grp,
  input  wire logic [31:0]                                     cmd_arg,
  output logic                                                 cmd_ready_r,
  output logic                                                 cmd_done_r,
  output logic                                                 cmd_err_r,
  // board inputs
  input  wire logic                                            reset_btn,
  input  wire logic                                            overtemp,
  input  wire logic                                            cc1_att,
  input  wire logic                                            cc2_att,
  // switch controls
  output logic [umc_pkg::GRP_N-1:0][umc_pkg::CHAN_N-1:0]       route_r,
  output logic                                                 flip_cc_r,
  output logic                                                 flip_ss_r,
  output logic                                                 flip_sbu_r,
  output logic                                                 flip_hs_r,
  output logic [umc_pkg::CHAN_N-1:0]                           keep_alive_charge_r,
  output logic                                                 boost_r,
  // readback
  output logic [umc_pkg::CHAN_W-1:0]                           sel_r,
  output logic [31:0]                                          mode_r,
  output logic                                                 split_r,
  output logic                                                 flip_r,
  output logic                                                 orient_r,
  output logic [31:0]                                          serial_r
);

  if (umc_pkg::BBM_CYC_INT < 1 || umc_pkg::BBM_CYC_INT > 6) begin : g_bbm_range
    $error("break-before-make count out of range");
  end

  umc_link_if lk ();

  umc_pkg::umc_cfg_s                                 cfg_r;
  umc_pkg::umc_state_e                               state_r;
  logic [7:0]                                        cnt_r;
  logic                                              save_req_r;
  logic [umc_pkg::GRP_N-1:0][umc_pkg::CHAN_N-1:0]    route_nxt;
  logic [umc_pkg::CHAN_N-1:0]                        kac_nxt;
  logic                                              acc;
  logic                                              idx_bad;
  logic                                              chan_cmd;
  logic                                              sel_change;

  // ------------------------------------------------------------------
  // sub-blocks
  // ------------------------------------------------------------------
  umc_nvm_store u_store (
    .clk      (clk),
    .por_nrst (por_nrst),
    .lk       (lk)
  );

  umc_orient_det u_det (
    .clk     (clk),
    .nrst    (nrst),
    .cc1_att (cc1_att),
    .cc2_att (cc2_att),
    .lk      (lk)
  );

  assign lk.save_req    = save_req_r;
  assign lk.restore_req = reset_btn;
  assign lk.save_rec    = cfg_r;

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  assign acc      = cmd_valid && cmd_ready_r && !reset_btn;
  assign chan_cmd = (cmd_op == umc_pkg::CMD_MODE) || (cmd_op == umc_pkg::CMD_PORT) ||
                    (cmd_op == umc_pkg::CMD_DATA) || (cmd_op == umc_pkg::CMD_HS);
  assign idx_bad  = (chan_cmd && cmd_idx != 8'h00) || (cmd_op > umc_pkg::CMD_BOOST);
  assign sel_change = acc && !idx_bad && cmd_op == umc_pkg::CMD_SELECT &&
                      cmd_arg[umc_pkg::CHAN_W-1:0] != cfg_r.sel;

  // ------------------------------------------------------------------
  // settings
  // ------------------------------------------------------------------
  // the button overrides everything, including boot load and commands
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_r <= umc_pkg::CFG_FACTORY;
    end else if (reset_btn) begin
      cfg_r <= umc_pkg::CFG_FACTORY;
    end else if (state_r == umc_pkg::ST_BOOT) begin
      cfg_r <= lk.load_rec;
    end else if (acc && !idx_bad) begin
      case (cmd_op)
        umc_pkg::CMD_SELECT: begin
          cfg_r.sel <= cmd_arg[umc_pkg::CHAN_W-1:0];
        end
        umc_pkg::CMD_MODE: begin
          cfg_r.mode <= cmd_arg & umc_pkg::MODE_WR_MASK;
        end
        umc_pkg::CMD_FLIP: begin
          cfg_r.flip <= cmd_arg[0];
        end
        umc_pkg::CMD_SPLIT: begin
          cfg_r.split <= cmd_arg[0];
        end
        umc_pkg::CMD_ASSIGN: begin
          // vbus takes a channel mask, other groups one channel
          if (cmd_grp == 3'(umc_pkg::G_VBUS)) begin
            cfg_r.vbus_mask <= cmd_arg[umc_pkg::CHAN_N-1:0];
          end else begin
            cfg_r.grp_chan[cmd_grp] <= cmd_arg[umc_pkg::CHAN_W-1:0];
          end
        end
        umc_pkg::CMD_PORT: begin
          cfg_r.mode <= cmd_arg[0] ? (cfg_r.mode | umc_pkg::PORT_MASK)
                                   : (cfg_r.mode & ~umc_pkg::PORT_MASK);
        end
        umc_pkg::CMD_DATA: begin
          cfg_r.mode <= cmd_arg[0] ? (cfg_r.mode | umc_pkg::DATA_MASK)
                                   : (cfg_r.mode & ~umc_pkg::DATA_MASK);
        end
        umc_pkg::CMD_HS: begin
          cfg_r.mode <= cmd_arg[0] ? (cfg_r.mode | umc_pkg::HS_MASK)
                                   : (cfg_r.mode & ~umc_pkg::HS_MASK);
        end
        umc_pkg::CMD_BOOST: begin
          cfg_r.boost <= cmd_arg[0];
        end
        default: begin
        end
      endcase
    end
  end

  // boost drives the redrivers only from the copy loaded at boot
  always_ff @(posedge clk) begin
    if (!nrst) begin
      boost_r <= 1'b0;
    end else if (state_r == umc_pkg::ST_BOOT) begin
      boost_r <= lk.load_rec.boost;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      save_req_r <= 1'b0;
    end else begin
      save_req_r <= acc && !idx_bad && cmd_op == umc_pkg::CMD_SAVE;
    end
  end

  // ------------------------------------------------------------------
  // break-before-make sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= umc_pkg::ST_BOOT;
      cnt_r   <= 8'h00;
    end else begin
      case (state_r)
        umc_pkg::ST_BOOT: begin
          state_r <= umc_pkg::ST_RUN;
        end
        umc_pkg::ST_RUN: begin
          if (sel_change) begin
            state_r <= umc_pkg::ST_OPEN;
            cnt_r   <= 8'h00;
          end
        end
        umc_pkg::ST_OPEN: begin
          if (cnt_r == umc_pkg::BBM_CYC - 8'h01) begin
            state_r <= umc_pkg::ST_RUN;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        default: begin
          state_r <= umc_pkg::ST_BOOT;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // routing
  // ------------------------------------------------------------------
  // enables carry no direction, so either side may be host or device
  always_comb begin
    route_nxt = '0;
    for (int g = 0; g < umc_pkg::GRP_N; g++) begin
      if (state_r == umc_pkg::ST_RUN && cfg_r.mode[umc_pkg::GRP_MB[g]]) begin
        if (!cfg_r.split) begin
          route_nxt[g] = umc_pkg::onehot(cfg_r.sel);
        end else if (g == umc_pkg::G_VBUS) begin
          route_nxt[g] = cfg_r.vbus_mask;
        end else begin
          route_nxt[g] = umc_pkg::onehot(cfg_r.grp_chan[g]);
        end
      end
    end
  end

  // the charger must never back-feed the channel tied to the common port
  always_comb begin
    kac_nxt = '0;
    if (cfg_r.mode[umc_pkg::MB_KAC] && !cfg_r.split && !overtemp) begin
      kac_nxt = ~umc_pkg::onehot(cfg_r.sel);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      route_r             <= '0;
      keep_alive_charge_r <= '0;
    end else begin
      route_r             <= route_nxt;
      keep_alive_charge_r <= kac_nxt;
    end
  end

  // a global flip and a detected reversed plug cancel each other out
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flip_cc_r  <= 1'b0;
      flip_ss_r  <= 1'b0;
      flip_sbu_r <= 1'b0;
      flip_hs_r  <= 1'b0;
    end else begin
      flip_cc_r  <= cfg_r.flip ^ cfg_r.mode[umc_pkg::MB_FCC] ^
                    (cfg_r.mode[umc_pkg::MB_AUTO] & lk.orient);
      flip_ss_r  <= cfg_r.flip ^ cfg_r.mode[umc_pkg::MB_FSS] ^
                    (cfg_r.mode[umc_pkg::MB_AUTO] & lk.orient);
      flip_sbu_r <= cfg_r.flip ^ cfg_r.mode[umc_pkg::MB_FSBU] ^
                    (cfg_r.mode[umc_pkg::MB_AUTO] & lk.orient);
      flip_hs_r  <= cfg_r.flip ^ cfg_r.mode[umc_pkg::MB_FHS] ^
                    (cfg_r.mode[umc_pkg::MB_AUTO] & lk.orient);
    end
  end

  // ------------------------------------------------------------------
  // command answers and readback
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_ready_r <= 1'b0;
      cmd_done_r  <= 1'b0;
      cmd_err_r   <= 1'b0;
    end else begin
      cmd_ready_r <= state_r == umc_pkg::ST_RUN && !sel_change;
      cmd_done_r  <= acc;
      cmd_err_r   <= acc && idx_bad;
    end
  end

  assign sel_r   = cfg_r.sel;
  assign mode_r  = cfg_r.mode;
  assign split_r = cfg_r.split;
  assign flip_r  = cfg_r.flip;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      orient_r <= 1'b0;
      serial_r <= 32'h0000_0000;
    end else begin
      orient_r <= lk.orient;
      serial_r <= SERIAL_ID;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_DEFAULT_ONE_CHAN: assert property (
    !$past(cfg_r.split) |-> $onehot0(route_r[0] | route_r[1] | route_r[2] | route_r[3] |
                                     route_r[4] | route_r[5] | route_r[6] | route_r[7]))
    else $error("two channels active in default mode");

  AST_DEFAULT_ROUTE: assert property (
    (state_r == umc_pkg::ST_RUN && !cfg_r.split && cfg_r.mode[umc_pkg::MB_VBUS] &&
     cfg_r.mode[umc_pkg::MB_SS1]) |=>
    (route_r[umc_pkg::G_VBUS] == umc_pkg::onehot($past(cfg_r.sel)) &&
     route_r[umc_pkg::G_SSA] == route_r[umc_pkg::G_VBUS]))
    else $error("default route does not follow selection");

  AST_SPLIT_ASSIGN: assert property (
    (state_r == umc_pkg::ST_RUN && cfg_r.split && cfg_r.mode[umc_pkg::MB_CC1]) |=>
    (route_r[umc_pkg::G_CC1] == umc_pkg::onehot($past(cfg_r.grp_chan[umc_pkg::G_CC1])) &&
     (!$past(cfg_r.mode[umc_pkg::MB_VBUS]) ||
      route_r[umc_pkg::G_VBUS] == $past(cfg_r.vbus_mask))))
    else $error("split assignment not applied");

  AST_KAC_NOT_SEL: assert property (
    1'b1 |=> (keep_alive_charge_r & umc_pkg::onehot($past(cfg_r.sel))) == '0)
    else $error("keep-alive charge on selected channel");

  AST_KAC_SPLIT_OFF: assert property (
    cfg_r.split |=> keep_alive_charge_r == '0)
    else $error("keep-alive charge active in split mode");

  AST_KAC_HOT_OFF: assert property (
    overtemp |=> keep_alive_charge_r == '0)
    else $error("keep-alive charge active while overtemperature");

  // mode and orientation held still, so only the flip setting can move the swaps
  AST_FLIP_SWAP: assert property (
    ($changed(cfg_r.flip) && $stable(cfg_r.mode) && $stable(lk.orient)) |=>
    ($changed(flip_cc_r) && $changed(flip_ss_r) && $changed(flip_sbu_r) &&
     $changed(flip_hs_r)))
    else $error("flip setting did not swap all sides");

  AST_PORT_CMD: assert property (
    (acc && !idx_bad && cmd_op == umc_pkg::CMD_PORT && !cmd_arg[0] && !reset_btn) |=>
    (cfg_r.mode & umc_pkg::PORT_MASK) == 32'h0000_0000)
    else $error("port disable left a path on");

  AST_DATA_CMD: assert property (
    (acc && !idx_bad && cmd_op == umc_pkg::CMD_DATA) |=>
    ($stable(cfg_r.mode[umc_pkg::MB_VBUS]) &&
     cfg_r.mode[umc_pkg::MB_SS1] == $past(cmd_arg[0])))
    else $error("data command touched vbus or missed ss");

  AST_HS_CMD: assert property (
    (acc && !idx_bad && cmd_op == umc_pkg::CMD_HS) |=>
    ($stable(cfg_r.mode[umc_pkg::MB_SS1]) && $stable(cfg_r.mode[umc_pkg::MB_VBUS]) &&
     cfg_r.mode[umc_pkg::MB_HSA] == $past(cmd_arg[0])))
    else $error("hs command touched another group");

  AST_BAD_IDX: assert property (
    (acc && chan_cmd && cmd_idx != 8'h00) |=> (cmd_err_r && $stable(cfg_r.mode)))
    else $error("bad channel index not refused");

  AST_BUTTON: assert property (
    reset_btn |=> cfg_r == umc_pkg::CFG_FACTORY)
    else $error("button did not restore defaults");

  AST_BBM: assert property (
    sel_change |=> ##1 (route_r == '0) [*5] ##1 state_r == umc_pkg::ST_RUN)
    else $error("channels not opened before close");

  CVR_SELECT: cover property (sel_change ##[1:10] state_r == umc_pkg::ST_RUN);
  CVR_SPLIT:  cover property (cfg_r.split && route_r[umc_pkg::G_VBUS] == 4'h3);
  CVR_FLIP:   cover property (flip_cc_r && flip_hs_r);
  CVR_SAVE:   cover property (save_req_r);
  CVR_ATTACH: cover property (lk.attached && lk.orient);

endmodule : umc_mux_ctrl

// ### umc_pkg.sv
// shared constants, types and helpers of the port mux controller
package umc_pkg;

  // ------------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------------
  localparam int CHAN_N = 4;
  localparam int GRP_N  = 8;
  localparam int CHAN_W = 2;

  // signal groups, in route vector order
  localparam int G_VBUS = 0;
  localparam int G_SSA  = 1;
  localparam int G_SSB  = 2;
  localparam int G_HSA  = 3;
  localparam int G_HSB  = 4;
  localparam int G_CC1  = 5;
  localparam int G_CC2  = 6;
  localparam int G_SBU  = 7;

  // ------------------------------------------------------------------
  // port mode word bit positions
  // ------------------------------------------------------------------
  localparam int MB_KAC  = 2;
  localparam int MB_HSA  = 4;
  localparam int MB_HSB  = 5;
  localparam int MB_VBUS = 6;
  localparam int MB_SS1  = 7;
  localparam int MB_SS2  = 8;
  localparam int MB_AUTO = 11;
  localparam int MB_CC1  = 12;
  localparam int MB_CC2  = 13;
  localparam int MB_SBU  = 14;
  localparam int MB_FCC  = 15;
  localparam int MB_FSS  = 16;
  localparam int MB_FSBU = 17;
  localparam int MB_FHS  = 18;

  // mode bit that enables each group, indexed by group
  localparam int GRP_MB [GRP_N] = '{MB_VBUS, MB_SS1, MB_SS2, MB_HSA,
                                    MB_HSB, MB_CC1, MB_CC2, MB_SBU};

  // reserved bits are dropped on write and read as zero
  localparam logic [31:0] MODE_WR_MASK = 32'h0007_f9f4;
  localparam logic [31:0] MODE_FACTORY = 32'h0000_79f0;
  localparam logic [31:0] PORT_MASK    = 32'h0000_01f0;
  localparam logic [31:0] DATA_MASK    = 32'h0000_01b0;
  localparam logic [31:0] HS_MASK      = 32'h0000_0030;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int BBM_TIME_NS   = 200;
  localparam int BBM_CYC_INT   = (BBM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] BBM_CYC = 8'(BBM_CYC_INT);

  // ------------------------------------------------------------------
  // commands, states, saved record
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_SELECT = 4'h0, CMD_MODE = 4'h1, CMD_FLIP  = 4'h2, CMD_SPLIT = 4'h3,
    CMD_ASSIGN = 4'h4, CMD_PORT = 4'h5, CMD_DATA  = 4'h6, CMD_HS    = 4'h7,
    CMD_SAVE   = 4'h8, CMD_BOOST = 4'h9
  } umc_cmd_e;

  typedef enum logic [1:0] {
    ST_BOOT = 2'h0, ST_RUN = 2'h1, ST_OPEN = 2'h3
  } umc_state_e;

  typedef struct packed {
    logic [CHAN_W-1:0]             sel;
    logic [31:0]                   mode;
    logic                          flip;
    logic                          split;
    logic [CHAN_N-1:0]             vbus_mask;
    logic [GRP_N-1:0][CHAN_W-1:0]  grp_chan;
    logic                          boost;
  } umc_cfg_s;

  localparam umc_cfg_s CFG_FACTORY = '{sel: 2'h0, mode: MODE_FACTORY, flip: 1'b0,
                                       split: 1'b0, vbus_mask: 4'h1, grp_chan: '0,
                                       boost: 1'b0};

  function automatic logic [CHAN_N-1:0] onehot(input logic [CHAN_W-1:0] c);
    onehot = 4'h1 << c;
  endfunction : onehot

endpackage : umc_pkg

// ### umc_link_if.sv
// carrier between the controller core, its settings store and the orientation detector
`timescale 1ns/1ps
interface umc_link_if;
  logic             save_req;
  logic             restore_req;
  umc_pkg::umc_cfg_s save_rec;
  umc_pkg::umc_cfg_s load_rec;
  logic             orient;
  logic             attached;

  modport core  (output save_req, output restore_req, output save_rec,
                 input load_rec, input orient, input attached);
  modport store (input save_req, input restore_req, input save_rec, output load_rec);
  modport det   (output orient, output attached);
endinterface : umc_link_if

// ### umc_nvm_store.sv
// non-volatile settings store: survives nrst, cleared at power-on and by the reset button
`timescale 1ns/1ps
module umc_nvm_store (
  // clock and power-on reset
  input  wire logic clk,
  input  wire logic por_nrst,
  // core side
  umc_link_if.store lk
);
  umc_pkg::umc_cfg_s store_r;

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  // restore wins over a save in the same cycle: the button is the stronger intent
  always_ff @(posedge clk) begin
    if (!por_nrst) begin
      store_r <= umc_pkg::CFG_FACTORY;
    end else if (lk.restore_req) begin
      store_r <= umc_pkg::CFG_FACTORY;
    end else if (lk.save_req) begin
      store_r <= lk.save_rec;
    end
  end

  assign lk.load_rec = store_r;

endmodule : umc_nvm_store

// ### umc_orient_det.sv
// cable orientation detector on the two cc attach levels
`timescale 1ns/1ps
module umc_orient_det (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // cc attach levels from the analog comparators
  input  wire logic cc1_att,
  input  wire logic cc2_att,
  // core side
  umc_link_if.det   lk
);
  logic orient_r;
  logic attached_r;

  // ------------------------------------------------------------------
  // detection
  // ------------------------------------------------------------------
  // both or neither attached is ambiguous: hold the last orientation
  always_ff @(posedge clk) begin
    if (!nrst) begin
      orient_r   <= 1'b0;
      attached_r <= 1'b0;
    end else begin
      attached_r <= cc1_att | cc2_att;
      if (cc1_att && !cc2_att) begin
        orient_r <= 1'b0;
      end else if (cc2_att && !cc1_att) begin
        orient_r <= 1'b1;
      end
    end
  end

  assign lk.orient   = orient_r;
  assign lk.attached = attached_r;

endmodule : umc_orient_det

// ### umc_cable_model.sv
// far side: a plugged cable that pulls one cc line, chosen by plug orientation
`timescale 1ns/1ps
module umc_cable_model (
  // clock
  input  wire logic clk,
  // plug orientation, 1 = reversed
  input  wire logic plug_rev,
  // cc attach levels toward the controller
  output logic      cc1_att,
  output logic      cc2_att
);
  // only one cc line is ever terminated by a single cable
  always_ff @(posedge clk) begin
    cc1_att <= !plug_rev;
    cc2_att <= plug_rev;
  end
endmodule : umc_cable_model

// ### usbc_port_mux_control_tb_top.sv
// self-checking bench of the port mux controller
`timescale 1ns/1ps
module usbc_port_mux_control_tb_top;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic clk, nrst, por_nrst, cmd_valid, reset_btn, overtemp, plug_rev, cc1, cc2;
  logic [3:0] cmd_op;
  logic [7:0] cmd_idx;
  logic [2:0] cmd_grp;
  logic [31:0] cmd_arg, route, mode, serial;
  logic rdy, done, err, fcc, fss, fsbu, fhs, boost, split, flip, orient;
  logic [3:0] keep_alive_charge;
  logic [1:0] sel;
  int err_total, samples_checked, cyc;
  umc_cable_model cab (.clk(clk), .plug_rev(plug_rev), .cc1_att(cc1), .cc2_att(cc2));
  umc_mux_ctrl #(.SERIAL_ID(32'h0000_00a5)) dut ( // arbitrary value
    .clk(clk), .nrst(nrst), .por_nrst(por_nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_idx(cmd_idx), .cmd_grp(cmd_grp), .cmd_arg(cmd_arg), .cmd_ready_r(rdy),
    .cmd_done_r(done), .cmd_err_r(err), .reset_btn(reset_btn), .overtemp(overtemp),
    .cc1_att(cc1), .cc2_att(cc2), .route_r(route), .flip_cc_r(fcc), .flip_ss_r(fss),
    .flip_sbu_r(fsbu), .flip_hs_r(fhs), .keep_alive_charge_r(keep_alive_charge), .boost_r(boost),
    .sel_r(sel), .mode_r(mode), .split_r(split), .flip_r(flip), .orient_r(orient),
    .serial_r(serial));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic wait_ready();
    int i;
    for (i = 0; i < 40 && rdy !== 1'b1; i++) @(negedge clk);
    chk(32'(rdy), 32'h1);
  endtask : wait_ready
  // returns 1 ns after the taking edge, while done still stands
  task automatic cmd(input logic [3:0] op, input logic [7:0] idx, input logic [2:0] grp,
                     input logic [31:0] arg, input logic e);
    @(posedge clk);
    {cmd_op, cmd_idx, cmd_grp, cmd_arg} <= {op, idx, grp, arg};
    cmd_valid <= 1'b1;
    @(negedge clk);
    wait_ready();
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk({30'h0, done, err}, {30'h0, 1'b1, e});
  endtask : cmd
  task automatic reboot();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    wait_ready();
  endtask : reboot
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_orient();
    plug_rev <= 1'b1;
    settle(6);
    chk(32'({orient, fcc, fss, fsbu, fhs}), 32'h1f);
    cmd(4'h2, 8'h0, 3'h0, 32'h1, 1'b0);
    settle(1);
    chk(32'({flip, fcc, fss, fsbu, fhs}), 32'h10);
    cmd(4'h2, 8'h0, 3'h0, 32'h0, 1'b0);
    plug_rev <= 1'b0;
    settle(6);
    chk(32'({flip, orient, fcc, fss, fsbu, fhs}), 32'h0);
  endtask : t_orient
  task automatic t_select();
    cmd(4'h0, 8'h0, 3'h0, 32'h2, 1'b0);
    chk(route, 32'h1111_1111);
    settle(1);
    chk(route, 32'h0);
    wait_ready();
    settle(1);
    chk(route, 32'h4444_4444);
    chk(32'(sel), 32'h2);
  endtask : t_select
  task automatic t_kac_ctl();
    // reserved bits 0, 1 and 19 are written and must read back as zero
    cmd(4'h1, 8'h0, 3'h0, 32'h0009_79f7, 1'b0);
    chk(mode, 32'h0001_79f4);
    settle(1);
    chk(32'({fss, keep_alive_charge}), 32'h1b);
    @(posedge clk) overtemp <= 1'b1;
    settle(2);
    chk(32'(keep_alive_charge), 32'h0);
    @(posedge clk) overtemp <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      cmd(4'(5 + i), 8'h0, 3'h0, 32'h0, 1'b0);
      chk(mode, 32'h0001_79f4 & ~(i == 0 ? 32'h1f0 : i == 1 ? 32'h1b0 : 32'h30));
      cmd(4'(5 + i), 8'h0, 3'h0, 32'h1, 1'b0);
      chk(mode, 32'h0001_79f4);
    end
    cmd(4'h5, 8'h1, 3'h0, 32'h0, 1'b1);
    cmd(4'ha, 8'h0, 3'h0, 32'h0, 1'b1);
    chk(mode, 32'h0001_79f4);
  endtask : t_kac_ctl
  task automatic t_split();
    cmd(4'h3, 8'h0, 3'h0, 32'h1, 1'b0);
    settle(1);
    chk(32'(keep_alive_charge), 32'h0);
    cmd(4'h4, 8'h0, 3'h0, 32'h3, 1'b0);
    cmd(4'h4, 8'h0, 3'h1, 32'h1, 1'b0);
    settle(1);
    chk(32'(route[7:0]), 32'h23);
    cmd(4'h4, 8'h0, 3'h0, 32'h4, 1'b0);
    settle(1);
    chk(32'(route[3:0]), 32'h4);
  endtask : t_split
  task automatic t_save();
    cmd(4'h9, 8'h0, 3'h0, 32'h1, 1'b0);
    settle(1);
    chk(32'(boost), 32'h0);
    cmd(4'h8, 8'h0, 3'h0, 32'h0, 1'b0);
    reboot();
    settle(2);
    chk(32'({boost, split, sel}), 32'he);
    @(posedge clk) reset_btn <= 1'b1;
    settle(2);
    @(posedge clk) reset_btn <= 1'b0;
    settle(1);
    chk({mode[28:0], split, sel}, {29'h79f0, 3'h0});
    // the store must have been cleared too, not only the live copy
    reboot();
    chk({mode[27:0], boost, split, sel}, {28'h79f0, 4'h0});
  endtask : t_save
  // ------------------------------------------------------------------
  // run
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    {nrst, por_nrst, cmd_valid, reset_btn, overtemp, plug_rev} = 6'h0;
    {cmd_op, cmd_idx, cmd_grp, cmd_arg} = '0;
    repeat (8) @(posedge clk);
    {nrst, por_nrst} <= 2'h3;
    @(negedge clk);
    wait_ready();
    chk(route, 32'h1111_1111);
    chk(serial, 32'h0000_00a5);
    t_orient();
    t_select();
    t_kac_ctl();
    t_split();
    t_save();
    tally_and_finish();
  end
endmodule : usbc_port_mux_control_tb_top
